// ### rtl/imhp_port.sv
// host message port: registers, transmit path, receive fifo, error packet, interrupt
// Notes on behaviour
// - error packet: five reads, count four first, then four bytes
// - write to error port ends the retrieval, data ignored
// - hardware or software reset enters init mode, init flag zero
// - host id write in init mode sets init flag, normal operation
// - after init, host id and configuration stay fixed until reset
// - no system bus activity started or answered in init mode
// - status reads 00000001 after reset
// - configuration reads back all zeros
// - all three interrupt enables cleared by any reset
// - bus transfer starts only on command write; stale fields resent
// - transmit, receive and error sequences independent, freely interleaved
// - queued received message sets receive flag; interrupt if enabled
// - receive: five data reads, then command read ends it
// - bus error, timeout or agent error sets transmit error flag
// - nack alone retries; error flag only when last retry nacked
// - error packet carries the failed attempt's request id
// - host id write after init drops interrupt line for nine cycles, 225 ns
// - interrupt line is OR of flags each ANDed with its enable
// - end of interrupt changes no other state
// - register addresses 0,1,2,3,4,5,7 as listed
// - status bits: 0 not full, 1 receive, 2 error, 7 init
// - control bits: 0 transmit, 1 receive, 2 error enable
// - receive pointer moves only on command read
`timescale 1ns/1ps
`default_nettype none
module imhp_port
    import imhp_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst,
    input  wire logic           host_rd,
    input  wire logic           host_wr,
    input  wire logic [2:0]     host_addr,
    input  wire logic [7:0]     host_wdata,
    output logic [7:0]          host_rdata,
    output logic                host_interrupt_line,
    output logic                bus_enable,
    output logic                tx_valid,
    input  wire logic           tx_ready,
    output imhp_pkt_type        tx_pkt,
    input  wire logic           tx_done,
    input  wire imhp_txres_type tx_res,
    input  wire logic           rx_valid,
    output logic                rx_ready,
    input  wire imhp_pkt_type   rx_pkt
);
    localparam logic [3:0] EOI_CNT = 4'(IMHP_EOI_CYC);
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} imhp_tx_type;

    imhp_tx_type  tx_st_r;
    logic         init_complete_flag;
    logic         sreset_pend_r;
    logic         sr_go;
    logic         clr;
    logic [7:0]   host_id_r;
    logic [2:0]   ctrl_r;
    logic         transmit_error_flag;
    logic         transmit_not_full_flag;
    logic         receive_not_empty_flag;
    imhp_pkt_type stage_r;
    imhp_pkt_type err_pkt_r;
    logic [2:0]   tx_idx_r;
    logic [2:0]   rx_idx_r;
    logic [2:0]   er_idx_r;
    logic [2:0]   retry_r;
    logic [3:0]   eoi_cnt_r;
    logic         irq_level;
    logic         eoi_now;
    logic         rd_data;
    logic         rd_cmd;
    logic         rd_err;
    logic         wr_cmd;
    logic         wr_hid;
    logic         gen_err;
    logic         nack_only;
    imhp_pkt_type rx_head;
    logic [31:0]  rx_head_w;

    // address decode
    assign rd_data = host_rd && host_addr == IMHP_A_DATA;
    assign rd_cmd  = host_rd && host_addr == IMHP_A_CMD;
    assign rd_err  = host_rd && host_addr == IMHP_A_ERROR;
    assign wr_cmd  = host_wr && host_addr == IMHP_A_CMD;
    assign wr_hid  = host_wr && host_addr == IMHP_A_HOSTID;
    assign eoi_now = wr_hid && init_complete_flag;
    assign gen_err = tx_res.bus_err || tx_res.timeout || tx_res.agent_err;
    assign nack_only = tx_res.nack && !gen_err;
    assign transmit_not_full_flag = (tx_st_r == TX_IDLE);
    assign rx_head = imhp_pkt_type'(rx_head_w);

    // soft reset waits out any bus transfer already handed over
    assign sr_go = sreset_pend_r && (tx_st_r == TX_IDLE ||
                   (tx_st_r == TX_SEND && !tx_ready));
    // fifo held cleared in init mode
    assign clr = sr_go || !init_complete_flag;

    imhp_fifo #(
        .WIDTH (32),
        .DEPTH (IMHP_FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .clr       (clr),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_pkt),
        .out_valid (receive_not_empty_flag),
        .out_ready (rd_cmd),
        .out_data  (rx_head_w)
    );

    always_ff @(posedge ref_clk) begin
        if (rst || sr_go) begin
            sreset_pend_r <= 1'b0;
        end else if (host_wr && host_addr == IMHP_A_STATUS) begin
            sreset_pend_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || sr_go) begin
            init_complete_flag <= 1'b0;
            host_id_r <= IMHP_HID_RESET;
        // host id taken only in init
        end else if (wr_hid && !init_complete_flag) begin
            init_complete_flag <= 1'b1;
            host_id_r <= host_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || sr_go) begin
            bus_enable <= 1'b0;
        end else begin
            bus_enable <= init_complete_flag;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || sr_go) begin
            ctrl_r <= IMHP_CTRL_RESET;
        end else if (host_wr && host_addr == IMHP_A_CTRL) begin
            ctrl_r <= host_wdata[2:0];
        end
    end

    // transmit staging; unwritten bytes keep old value
    always_ff @(posedge ref_clk) begin
        if (rst || sr_go) begin
            tx_idx_r <= '0;
            stage_r <= '0;
        end else if (wr_cmd) begin
            tx_idx_r <= '0;
        end else if (host_wr && host_addr == IMHP_A_DATA) begin
            unique case (tx_idx_r)
                3'h0: stage_r.dst <= host_wdata;
                3'h1: stage_r.src <= host_wdata;
                3'h2: stage_r.kind <= host_wdata;
                3'h3: stage_r.req <= host_wdata;
                default: ;
            endcase
            if (tx_idx_r != 3'h4) begin
                tx_idx_r <= tx_idx_r + 3'h1;
            end
        end
    end

    // transmit sequencer
    always_ff @(posedge ref_clk) begin
        if (rst || sr_go) begin
            tx_st_r <= TX_IDLE;
            tx_valid <= 1'b0;
            tx_pkt <= '0;
            retry_r <= '0;
        end else begin
            unique case (tx_st_r)
                TX_IDLE: begin
                    if (wr_cmd && init_complete_flag) begin
                        tx_st_r <= TX_SEND;
                        tx_valid <= 1'b1;
                        tx_pkt <= stage_r;
                        retry_r <= IMHP_RETRIES;
                    end
                end
                TX_SEND: begin
                    if (tx_ready) begin
                        tx_st_r <= TX_WAIT;
                        tx_valid <= 1'b0;
                    end
                end
                TX_WAIT: begin
                    // nack alone retries while any left
                    if (tx_done && nack_only && retry_r != 3'h0) begin
                        tx_st_r <= TX_SEND;
                        tx_valid <= 1'b1;
                        retry_r <= retry_r - 3'h1;
                    end else if (tx_done) begin
                        tx_st_r <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // error set beats the host's clear
    always_ff @(posedge ref_clk) begin
        if (rst || sr_go) begin
            transmit_error_flag <= 1'b0;
            err_pkt_r <= '0;
        end else if (tx_st_r == TX_WAIT && tx_done &&
                     (gen_err || (tx_res.nack && retry_r == 3'h0))) begin
            transmit_error_flag <= 1'b1;
            err_pkt_r <= tx_pkt;
        end else if (host_wr && host_addr == IMHP_A_ERROR) begin
            transmit_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || sr_go || rd_cmd) begin
            rx_idx_r <= '0;
        end else if (rd_data && rx_idx_r != 3'h5) begin
            rx_idx_r <= rx_idx_r + 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || sr_go || (host_wr && host_addr == IMHP_A_ERROR)) begin
            er_idx_r <= '0;
        end else if (rd_err && er_idx_r != 3'h5) begin
            er_idx_r <= er_idx_r + 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            host_rdata <= '0;
        end else if (host_rd) begin
            unique case (host_addr)
                IMHP_A_STATUS: begin
                    host_rdata <= '0;
                    host_rdata[IMHP_ST_TXNF] <= transmit_not_full_flag;
                    host_rdata[IMHP_ST_RXNE] <= receive_not_empty_flag;
                    host_rdata[IMHP_ST_TXERR] <= transmit_error_flag;
                    host_rdata[IMHP_ST_INIT] <= init_complete_flag;
                end
                IMHP_A_HOSTID: host_rdata <= host_id_r;
                IMHP_A_CONFIG: host_rdata <= IMHP_CFG_VALUE;
                IMHP_A_CTRL: host_rdata <= {5'h00, ctrl_r};
                IMHP_A_DATA: begin
                    unique case (rx_idx_r)
                        3'h0: host_rdata <= IMHP_PKT_LEN;
                        3'h1: host_rdata <= rx_head.dst;
                        3'h2: host_rdata <= rx_head.src;
                        3'h3: host_rdata <= rx_head.kind;
                        3'h4: host_rdata <= rx_head.req;
                        default: host_rdata <= '0;
                    endcase
                end
                IMHP_A_ERROR: begin
                    unique case (er_idx_r)
                        3'h0: host_rdata <= IMHP_PKT_LEN;
                        3'h1: host_rdata <= err_pkt_r.dst;
                        3'h2: host_rdata <= err_pkt_r.src;
                        3'h3: host_rdata <= err_pkt_r.kind;
                        3'h4: host_rdata <= err_pkt_r.req;
                        default: host_rdata <= '0;
                    endcase
                end
                default: host_rdata <= '0;
            endcase
        end
    end

    assign irq_level = (transmit_not_full_flag && ctrl_r[IMHP_CT_TXIE]) ||
                       (receive_not_empty_flag && ctrl_r[IMHP_CT_RXIE]) ||
                       (transmit_error_flag && ctrl_r[IMHP_CT_ERROR_IRQ_ENABLE]);

    always_ff @(posedge ref_clk) begin
        if (rst || sr_go) begin
            eoi_cnt_r <= '0;
        end else if (eoi_now) begin
            eoi_cnt_r <= EOI_CNT;
        end else if (eoi_cnt_r != 4'h0) begin
            eoi_cnt_r <= eoi_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || sr_go) begin
            host_interrupt_line <= 1'b0;
        end else begin
            host_interrupt_line <= irq_level && !eoi_now && eoi_cnt_r == 4'h0;
        end
    end

    property p_reset_init;
        @(posedge ref_clk) rst |=> !init_complete_flag && !bus_enable;
    endproperty
    a_reset_init: assert property (p_reset_init) else $error("init flag after reset");

    property p_init_set;
        @(posedge ref_clk) disable iff (rst)
        (wr_hid && !init_complete_flag && !sr_go) |=> init_complete_flag ##1 bus_enable;
    endproperty
    a_init_set: assert property (p_init_set) else $error("host id write did not end init");

    property p_hid_frozen;
        @(posedge ref_clk) disable iff (rst)
        (init_complete_flag && !sr_go) |=> host_id_r == $past(host_id_r);
    endproperty
    a_hid_frozen: assert property (p_hid_frozen) else $error("host id changed after init");

    property p_no_bus_init;
        @(posedge ref_clk) disable iff (rst)
        !init_complete_flag |-> !tx_valid && !(rx_valid && rx_ready && !clr);
    endproperty
    a_no_bus_init: assert property (p_no_bus_init) else $error("bus activity in init mode");

    property p_cfg_zero;
        @(posedge ref_clk) disable iff (rst)
        host_rd && host_addr == IMHP_A_CONFIG |=> host_rdata == 8'h00;
    endproperty
    a_cfg_zero: assert property (p_cfg_zero) else $error("config read not zero");

    property p_irq_reset;
        @(posedge ref_clk) rst |=> !host_interrupt_line && ctrl_r == 3'h0;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("interrupt live after reset");

    property p_start_cmd;
        @(posedge ref_clk) disable iff (rst)
        (tx_st_r == TX_IDLE && !wr_cmd) |=> !tx_valid;
    endproperty
    a_start_cmd: assert property (p_start_cmd) else $error("transfer without command write");

    property p_gen_err;
        @(posedge ref_clk) disable iff (rst)
        (tx_st_r == TX_WAIT && tx_done && gen_err && !sr_go) |=> transmit_error_flag;
    endproperty
    a_gen_err: assert property (p_gen_err) else $error("error flag not set");

    property p_nack_retry;
        @(posedge ref_clk) disable iff (rst)
        (tx_st_r == TX_WAIT && tx_done && nack_only && retry_r != 3'h0 && !sr_go)
        |=> tx_valid && $stable(tx_pkt) && !$rose(transmit_error_flag);
    endproperty
    a_nack_retry: assert property (p_nack_retry) else $error("nack did not retry");

    property p_eoi_low;
        @(posedge ref_clk) disable iff (rst || sr_go)
        eoi_now |=> !host_interrupt_line [*8];
    endproperty
    a_eoi_low: assert property (p_eoi_low) else $error("eoi low time short");

    property p_irq_level;
        @(posedge ref_clk) disable iff (rst || sr_go)
        (eoi_cnt_r == 4'h0 && !eoi_now && !sr_go) |=> host_interrupt_line == $past(irq_level);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt line wrong");

    property p_eoi_quiet;
        @(posedge ref_clk) disable iff (rst)
        (eoi_now && !sr_go && !tx_done) |=> $stable(ctrl_r) && $stable(transmit_error_flag) &&
        $stable(init_complete_flag);
    endproperty
    a_eoi_quiet: assert property (p_eoi_quiet) else $error("eoi changed state");
endmodule
`default_nettype wire

// ### rtl/imhp_pkg.sv
// shared constants and packet types for the interrupt message host port
package imhp_pkg;
    localparam logic [2:0] IMHP_A_STATUS = 3'h0;
    localparam logic [2:0] IMHP_A_HOSTID = 3'h1;
    localparam logic [2:0] IMHP_A_CONFIG = 3'h2;
    localparam logic [2:0] IMHP_A_CTRL   = 3'h3;
    localparam logic [2:0] IMHP_A_DATA   = 3'h4;
    localparam logic [2:0] IMHP_A_ERROR  = 3'h5;
    localparam logic [2:0] IMHP_A_CMD    = 3'h7;
    localparam int IMHP_ST_TXNF = 0;
    localparam int IMHP_ST_RXNE = 1;
    localparam int IMHP_ST_TXERR = 2;
    localparam int IMHP_ST_INIT = 7;
    localparam int IMHP_CT_TXIE = 0;
    localparam int IMHP_CT_RXIE = 1;
    localparam int IMHP_CT_ERROR_IRQ_ENABLE = 2;
    localparam logic [7:0] IMHP_PKT_LEN   = 8'h04;
    localparam logic [7:0] IMHP_CFG_VALUE = 8'h00;
    localparam logic [7:0] IMHP_HID_RESET = 8'h00;
    localparam logic [2:0] IMHP_CTRL_RESET = 3'h0;
    localparam logic [2:0] IMHP_RETRIES  = 3'h3;
    localparam int IMHP_CLK_MHZ = 40;
    localparam int IMHP_EOI_NS  = 200;
    localparam int IMHP_EOI_CYC = (IMHP_EOI_NS * IMHP_CLK_MHZ + 999) / 1000;
    localparam int IMHP_FIFO_DEPTH = 4;
    typedef struct packed {
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] kind;
        logic [7:0] req;
    } imhp_pkt_type;
    typedef struct packed {
        logic bus_err;
        logic timeout;
        logic agent_err;
        logic nack;
    } imhp_txres_type;
endpackage

// ### rtl/imhp_fifo.sv
// receive message fifo with registered ready and valid
`timescale 1ns/1ps
`default_nettype none
module imhp_fifo
    import imhp_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clr,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             push;
    logic             pop;

    assign push = in_valid && in_ready && !clr;
    assign pop = out_valid && out_ready && !clr;
    assign out_data = mem[rptr_r];

    always_comb begin
        count_nxt = count_r;
        if (clr) begin
            count_nxt = '0;
        end else if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || clr) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
            end
        end
    end

    // ready is held low by clr so init mode never takes a word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_r <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            count_r <= count_nxt;
            in_ready <= !clr && (count_nxt != (AW+1)'(DEPTH));
            out_valid <= (count_nxt != '0);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_mem
            always_ff @(posedge ref_clk) begin
                if (push && wptr_r == AW'(gi)) begin
                    mem[gi] <= in_data;
                end
            end
        end
    endgenerate

    property p_no_over;
        @(posedge ref_clk) disable iff (rst)
        count_r == (AW+1)'(DEPTH) |-> !in_ready;
    endproperty
    a_no_over: assert property (p_no_over) else $error("fifo ready while full");
endmodule
`default_nettype wire

// ### testbench/imhp_bus_model.sv
// system bus agent model: takes transmit packets, offers receive packets
`timescale 1ns/1ps
`default_nettype none
module imhp_bus_model
    import imhp_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst,
    input  wire logic           tx_valid,
    output logic                tx_ready,
    input  wire imhp_pkt_type   tx_pkt,
    output logic                tx_done,
    output imhp_txres_type      tx_res,
    output logic                rx_valid,
    input  wire logic           rx_ready,
    output imhp_pkt_type        rx_pkt,
    input  wire imhp_txres_type res_mode,
    input  wire logic [3:0]     stall,
    input  wire logic           rx_go,
    input  wire imhp_pkt_type   rx_word,
    output imhp_pkt_type        got_pkt,
    output int                  taken
);
    logic [3:0]   cnt_r;
    logic         busy_r;
    imhp_pkt_type hold_r;
    // released lines show the inverse, never a stale copy
    assign tx_res = tx_done ? res_mode : ~res_mode;
    assign rx_pkt = rx_valid ? hold_r : ~hold_r;
    always_ff @(posedge ref_clk) begin
        tx_ready <= 1'b0;
        tx_done  <= 1'b0;
        if (rst) begin
            busy_r <= 1'b0;
            cnt_r  <= 4'h0;
            taken  <= 0;
        end else if (tx_valid && tx_ready) begin
            busy_r  <= 1'b1;
            cnt_r   <= 4'h0;
            got_pkt <= tx_pkt;
            taken   <= taken + 1;
        end else if (busy_r) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h2) begin
                busy_r  <= 1'b0;
                tx_done <= 1'b1;
                cnt_r   <= 4'h0;
            end
        end else if (tx_valid) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r >= stall) begin
                tx_ready <= 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_valid <= 1'b0;
            hold_r   <= '0;
        end else if (rx_valid && rx_ready) begin
            rx_valid <= 1'b0;
        end else if (rx_go) begin
            rx_valid <= 1'b1;
            hold_r   <= rx_word;
        end
    end
endmodule
`default_nettype wire

// ### testbench/test_interrupt_message_host_port.sv
// self-checking bench for the message host port
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_message_host_port import imhp_pkg::*;;
    logic           ref_clk, rst, host_rd, host_wr, host_interrupt_line, bus_enable;
    logic [2:0]     host_addr;
    logic [7:0]     host_wdata, host_rdata, rv;
    logic           tx_valid, tx_ready, tx_done, rx_valid, rx_ready, rx_go;
    imhp_pkt_type   tx_pkt, rx_pkt, rx_word, got_pkt;
    imhp_txres_type tx_res, res_mode;
    logic [3:0]     stall;
    int             taken, n_fail, checks_done;
    imhp_port u_dut (.ref_clk(ref_clk), .rst(rst), .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_interrupt_line(host_interrupt_line),
        .bus_enable(bus_enable), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pkt(tx_pkt), .tx_done(tx_done),
        .tx_res(tx_res), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_pkt(rx_pkt));
    imhp_bus_model u_bus (.ref_clk(ref_clk), .rst(rst), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pkt(tx_pkt),
        .tx_done(tx_done), .tx_res(tx_res), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_pkt(rx_pkt),
        .res_mode(res_mode), .stall(stall), .rx_go(rx_go), .rx_word(rx_word), .got_pkt(got_pkt), .taken(taken));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        host_wr    <= 1'b1;
        host_addr  <= a;
        host_wdata <= d;
        @(posedge ref_clk);
        host_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge ref_clk);
        host_rd   <= 1'b1;
        host_addr <= a;
        @(posedge ref_clk);
        host_rd <= 1'b0;
        #1 rv = host_rdata;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        rd(a);
        chk(rv, e);
    endtask
    task automatic rpkt(input logic [2:0] a, input imhp_pkt_type p);
        rchk(a, IMHP_PKT_LEN);
        for (int i = 3; i >= 0; i--) rchk(a, p[i*8+:8]);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic send(input imhp_pkt_type w);
        @(posedge ref_clk);
        rx_word <= w;
        rx_go   <= 1'b1;
        @(posedge ref_clk);
        rx_go <= 1'b0;
        #1;
    endtask
    // bounded wait for a count of taken packets, then for not-full again
    task automatic txw(input int n);
        for (int i = 0; i < 100 && taken != n; i++) @(posedge ref_clk);
        chk(taken, n);
        for (int i = 0; i < 20; i++) begin
            rd(IMHP_A_STATUS);
            if (rv[IMHP_ST_TXNF] === 1'b1) break;
        end
    endtask
    task automatic t_reset;
        send(32'h11223344);
        rchk(IMHP_A_STATUS, 8'h01);
        chk(host_interrupt_line, 1'b0);
        chk(bus_enable, 1'b0);
        wr(IMHP_A_CONFIG, 8'hff);
        rchk(IMHP_A_CONFIG, IMHP_CFG_VALUE);
        chk(rx_ready, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_init;
        wr(IMHP_A_HOSTID, 8'h5a);
        wt(3);
        chk(bus_enable, 1'b1);
        rchk(IMHP_A_STATUS, 8'h83);
        wr(IMHP_A_HOSTID, 8'h00);
        wr(IMHP_A_CONFIG, 8'h3c);
        rchk(IMHP_A_HOSTID, 8'h5a);
        rchk(IMHP_A_CONFIG, IMHP_CFG_VALUE);
        $display("test init done");
    endtask
    task automatic t_rx;
        imhp_pkt_type q[$];
        q.push_back(32'h11223344);
        // one more than the fifo holds, so the far side stalls
        for (int i = 1; i < 5; i++) begin
            q.push_back(32'ha1b2c300 + i);
            send(q[i]);
            for (int j = 0; j < 20 && rx_valid; j++) @(posedge ref_clk);
        end
        chk(rx_ready, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rpkt(IMHP_A_DATA, q[i]);
            rd(IMHP_A_DATA);
            rchk(IMHP_A_STATUS, 8'h83);
            rd(IMHP_A_CMD);
        end
        rchk(IMHP_A_STATUS, 8'h81);
        $display("test receive done");
    endtask
    task automatic t_tx;
        wr(IMHP_A_DATA, 8'h21);
        send(32'h55667788);
        wr(IMHP_A_DATA, 8'h5a);
        rpkt(IMHP_A_DATA, 32'h55667788);
        wr(IMHP_A_DATA, 8'h00);
        wr(IMHP_A_DATA, 8'h07);
        chk(taken, 0);
        wr(IMHP_A_CMD, 8'h00);
        rd(IMHP_A_CMD);
        txw(1);
        chk(got_pkt, 32'h215a0007);
        wr(IMHP_A_DATA, 8'h33);
        wr(IMHP_A_CMD, 8'h00);
        txw(2);
        chk(got_pkt, 32'h335a0007);
        $display("test transmit done");
    endtask
    task automatic t_err;
        res_mode <= 4'b1000;
        wr(IMHP_A_CTRL, 8'h04);
        wr(IMHP_A_DATA, 8'h44);
        wr(IMHP_A_CMD, 8'h00);
        txw(3);
        rchk(IMHP_A_STATUS, 8'h85);
        chk(host_interrupt_line, 1'b1);
        wr(IMHP_A_HOSTID, 8'h00);
        wt(1);
        chk(host_interrupt_line, 1'b0);
        wt(7);
        chk(host_interrupt_line, 1'b0);
        wt(4);
        chk(host_interrupt_line, 1'b1);
        rpkt(IMHP_A_ERROR, 32'h445a0007);
        rchk(IMHP_A_STATUS, 8'h85);
        wr(IMHP_A_ERROR, 8'h00);
        rchk(IMHP_A_STATUS, 8'h81);
        chk(host_interrupt_line, 1'b0);
        $display("test error done");
    endtask
    task automatic t_nack;
        res_mode <= 4'b0001;
        wr(IMHP_A_CMD, 8'h00);
        for (int i = 0; i < 100 && taken != 5; i++) @(posedge ref_clk);
        rd(IMHP_A_STATUS);
        chk(rv[IMHP_ST_TXERR], 1'b0);
        txw(4 + IMHP_RETRIES);
        rchk(IMHP_A_STATUS, 8'h85);
        wr(IMHP_A_ERROR, 8'h00);
        rchk(IMHP_A_STATUS, 8'h81);
        $display("test retry done");
    endtask
    task automatic t_swrst;
        wr(IMHP_A_CTRL, 8'h03);
        wt(2);
        chk(host_interrupt_line, 1'b1);
        wr(IMHP_A_STATUS, 8'h00);
        wt(2);
        rchk(IMHP_A_STATUS, 8'h01);
        chk(host_interrupt_line, 1'b0);
        wr(IMHP_A_HOSTID, 8'h17);
        rchk(IMHP_A_HOSTID, 8'h17);
        $display("test soft reset done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        report_and_stop;
    end
    initial begin
        rst        = 1'b1;
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        host_addr  = 3'h0;
        host_wdata = 8'h00;
        rx_go      = 1'b0;
        rx_word    = '0;
        res_mode   = '0;
        stall      = 4'h2;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_init;
        t_rx;
        t_tx;
        t_err;
        t_nack;
        t_swrst;
        report_and_stop;
    end
endmodule
`default_nettype wire
